/* hw/cpc_perm_map.svh */
// constants of the capability permission codec: format sizes, codes, reset values
`ifndef CPC_PERM_MAP_SVH
`define CPC_PERM_MAP_SVH

// ----------------------------------------------------------------------------
// capability format sizes
// ----------------------------------------------------------------------------
`define CPC_MANTISSA_WIDTH      10
`define CPC_EXPONENT_WIDTH      5
`define CPC_MAX_EXP             5'h18
`define CPC_MAX_EXP_WIDE        6'h34
`define CPC_LEN_MSB_PRESENT     1'h1
`define CPC_MODE_IN_FIELD       1'h1
`define CPC_SDP_WIDTH           2
`define CPC_FIELD_WIDTH         5
`define CPC_REPR_SHIFT          2

// ----------------------------------------------------------------------------
// field positions and quadrants
// ----------------------------------------------------------------------------
`define CPC_QUAD_HI             4
`define CPC_QUAD_LO             3
`define CPC_QUAD_DATA           2'h0
`define CPC_QUAD_EXEC           2'h1
`define CPC_QUAD_RCAP           2'h2
`define CPC_QUAD_CAP            2'h3

// ----------------------------------------------------------------------------
// permission field codes
// ----------------------------------------------------------------------------
`define CPC_CODE_NONE           5'h00
`define CPC_CODE_RO             5'h01
`define CPC_CODE_WO             5'h04
`define CPC_CODE_RW             5'h05
`define CPC_CODE_X_ALL          5'h08
`define CPC_CODE_X_RO           5'h0A
`define CPC_CODE_X_RW_CAP       5'h0C
`define CPC_CODE_X_RW           5'h0E
`define CPC_CODE_CAP_RO_NOLM    5'h13
`define CPC_CODE_CAP_RO         5'h1B
`define CPC_CODE_CAP_RW         5'h1F
`define CPC_FULL_CODE           5'h08
`define CPC_FULL_CODE_HYBRID    5'h09

// ----------------------------------------------------------------------------
// reset values of the registered outputs
// ----------------------------------------------------------------------------
`define CPC_RST_FIELD           5'h00
`define CPC_RST_ADDR            32'h0000_0000

`endif

/* hw/cpc_pkg.sv */
// types shared by the capability permission codec
`default_nettype none

package cpc_pkg;

    // ------------------------------------------------------------------------
    // decoded architectural permissions
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic r;
        logic w;
        logic c;
        logic lm;
        logic x;
        logic system_register_access_perm;
    } cpc_perm_t;

    // ------------------------------------------------------------------------
    // special capability selector
    // ------------------------------------------------------------------------
    typedef enum logic {
        CPC_SPC_NULL,
        CPC_SPC_INFINITE
    } cpc_spc_t;

    // ------------------------------------------------------------------------
    // registered state of the top
    // ------------------------------------------------------------------------
    typedef struct packed {
        cpc_perm_t   read_perms;
        logic        read_mode;
        logic        code_ok;
        logic        fmt_ok;
        logic [4:0]  restr_field;
        logic [4:0]  modew_field;
        logic        spc_tag;
        logic [1:0]  spc_sdp;
        logic [4:0]  spc_field;
        logic        spc_ext_perm;
        logic [31:0] spc_addr;
    } cpc_state_t;

endpackage

`default_nettype wire

/* hw/cpc_perm_decode.sv */
// decoder of the compressed permission and mode field
`include "cpc_perm_map.svh"
`default_nettype none

module cpc_perm_decode #(
    parameter bit HYBRID = 1'b0
) (
    // field in
    input  wire logic [4:0]        i_arch_permission_field,
    // decoded out
    output cpc_pkg::cpc_perm_t     o_perms,
    output logic                   o_mode,
    output logic                   o_code_ok
);

    logic [1:0]         quad;
    logic [2:0]         low;
    cpc_pkg::cpc_perm_t p;
    logic               m;
    logic               ok;

    always_comb begin
        quad = i_arch_permission_field[`CPC_QUAD_HI:`CPC_QUAD_LO];
        low  = i_arch_permission_field[2:0];
        p    = '0;
        m    = 1'b0;
        ok   = 1'b0;
        case (quad)
            `CPC_QUAD_DATA: begin
                ok = (low == 3'h0) || (low == 3'h1) || (low == 3'h4) || (low == 3'h5);
                p.r = low[0];
                p.w = low[2];
            end
            `CPC_QUAD_EXEC: begin
                p.x = 1'b1;
                p.r = 1'b1;
                p.w = (low[2:1] != 2'h1);
                p.c = (low[2:1] != 2'h3);
                p.lm = (low[2:1] != 2'h3);
                p.system_register_access_perm = (low[2:1] == 2'h0);
                m = low[0];
                // an address-mode code without the hybrid mode is a reserved code
                ok = HYBRID || !low[0];
            end
            `CPC_QUAD_RCAP: begin
                ok = (low == 3'h3);
                p.r = 1'b1;
                p.c = 1'b1;
            end
            `CPC_QUAD_CAP: begin
                ok = (low == 3'h3) || (low == 3'h7);
                p.r = 1'b1;
                p.c = 1'b1;
                p.lm = 1'b1;
                p.w = low[2];
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        if (!ok) begin
            p = '0;
            m = 1'b0;
        end
        o_perms   = p;
        o_mode    = m & HYBRID;
        o_code_ok = ok;
    end

endmodule

`default_nettype wire

/* hw/cpc_perm_restrict.sv */
// ordered permission restriction and re-encoding into the compressed field
`include "cpc_perm_map.svh"
`default_nettype none

module cpc_perm_restrict #(
    parameter bit HYBRID = 1'b0
) (
    // current and requested
    input  wire cpc_pkg::cpc_perm_t i_cur_perms,
    input  wire cpc_pkg::cpc_perm_t i_keep_mask,
    input  wire logic               i_mode,
    // encoded result
    output logic [4:0]              o_field
);

    cpc_pkg::cpc_perm_t p;
    logic               m;
    logic [4:0]         f;

    always_comb begin
        // rules run once and in this order instead of iterating to a fixed point
        p = i_cur_perms & i_keep_mask;
        if (!p.r) p.c = 1'b0;
        if (!p.r) p.x = 1'b0;
        if (!(!p.c || p.lm)) p.w = 1'b0;
        if (!(p.w || p.c)) p.x = 1'b0;
        if (!p.c) p.lm = 1'b0;
        if (!((p.c && p.lm) || !(p.c || p.lm))) p.x = 1'b0;
        if (!(p.w && p.c && p.x)) p.system_register_access_perm = 1'b0;
        m = i_mode & p.x & HYBRID;
        // every combination left by the rules has a code, so no reserved code leaves here
        f = `CPC_CODE_NONE;
        if (p.x) begin
            if (p.system_register_access_perm) f = `CPC_CODE_X_ALL;
            else if (!p.w) f = `CPC_CODE_X_RO;
            else if (p.c) f = `CPC_CODE_X_RW_CAP;
            else f = `CPC_CODE_X_RW;
            f[0] = m;
        end else if (p.c) begin
            if (!p.lm) f = `CPC_CODE_CAP_RO_NOLM;
            else if (p.w) f = `CPC_CODE_CAP_RW;
            else f = `CPC_CODE_CAP_RO;
        end else begin
            case ({p.w, p.r})
                2'h1:    f = `CPC_CODE_RO;
                2'h2:    f = `CPC_CODE_WO;
                2'h3:    f = `CPC_CODE_RW;
                default: f = `CPC_CODE_NONE;
            endcase
        end
        o_field = f;
    end

endmodule

`default_nettype wire

/* hw/cpc_perm_codec.sv */
// capability permission codec: field decode, restriction, mode write, special values
//
// How it works
// - NULL capability has every field zero.
// - Infinite: tag, all-ones software bits, full code.
// - extension permissions absent in NULL, present Infinite.
// - valid capability needs all reserved bits zero.
// - no hybrid mode: mode bit reads zero.
// - no levels: extra codes reserved, global flag zero.
// - mantissa 10, exponent field 5, max 24.
// - length msb present, mode inside permission field.
// - full code 0x8, or 0x9 with hybrid.
// - bits 4:3 pick quadrant, 2:0 meaning.
// - executable quadrant bit 0 is mode bit.
// - quadrant 0: none, read, write, read-write.
// - quadrant 1: four executable permission sets.
// - quadrant 2: only 3, read plus capability.
// - quadrant 3: 3 read-only, 7 adds write.
// - reserved code reads as no permissions.
// - restriction never produces a reserved code.
// - mode write leaves granted permissions unchanged.
// - restriction uses ordered once-through procedure.
// - first five ordered restriction checks.
// - last three ordered checks, mode needs execute.
// - a quarter of size stays representable.
`include "cpc_perm_map.svh"
`default_nettype none

module cpc_perm_codec #(
    parameter bit          HYBRID       = 1'b0,
    parameter int unsigned RESV_WIDTH   = 1,
    parameter int unsigned MANT_WIDTH   = `CPC_MANTISSA_WIDTH,
    parameter int unsigned EXP_WIDTH    = `CPC_EXPONENT_WIDTH
) (
    // clock, reset, enable
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rstn,
    input  wire logic                       i_ce,
    // capability under inspection
    input  wire logic [4:0]                 i_arch_permission_field,
    input  wire logic                       i_tag,
    input  wire logic                       i_unbounded_lifetime_flag,
    input  wire logic [RESV_WIDTH-1:0]      i_reserved_bits,
    // restrict and mode write requests
    input  wire cpc_pkg::cpc_perm_t         i_keep_mask,
    input  wire logic                       i_new_mode,
    // special capability request
    input  wire cpc_pkg::cpc_spc_t          i_spc_sel,
    input  wire logic [31:0]                i_spc_addr,
    // read permissions result
    output cpc_pkg::cpc_perm_t              o_read_perms,
    output logic                            o_read_mode,
    output logic                            o_code_ok,
    output logic                            o_fmt_ok,
    // restrict and mode write results
    output logic [4:0]                      o_restr_field,
    output logic [4:0]                      o_modew_field,
    // special capability fields
    output logic                            o_spc_tag,
    output logic [`CPC_SDP_WIDTH-1:0]       o_spc_sdp,
    output logic [4:0]                      o_spc_field,
    output logic                            o_spc_seal_type_bit,
    output logic                            o_spc_exponent_format_flag,
    output logic                            o_spc_length_msb_bit,
    output logic [MANT_WIDTH-1:0]           o_spc_top,
    output logic [MANT_WIDTH-1:0]           o_spc_base,
    output logic                            o_spc_ext_perm,
    output logic [31:0]                     o_spc_addr,
    // fixed format properties
    output logic [EXP_WIDTH-1:0]            o_max_exponent,
    output logic                            o_length_msb_bit_present,
    output logic                            o_mode_bit_in_permission_field,
    output logic [3:0]                      o_repr_margin_shift
);

    // ------------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------------
    logic [1:0] rst_pipe_q;
    logic       rstn_sync;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end

    assign rstn_sync = rst_pipe_q[1];

    // ------------------------------------------------------------------------
    // combinational datapath
    // ------------------------------------------------------------------------
    cpc_pkg::cpc_perm_t dec_perms;
    logic               dec_mode;
    logic               dec_ok;
    logic [4:0]         restr_field;
    logic [4:0]         modew_field;

    // all three paths settle within the cycle, the flops below only hold results
    cpc_perm_decode #(
        .HYBRID                  (HYBRID)
    ) u_decode (
        .i_arch_permission_field (i_arch_permission_field),
        .o_perms                 (dec_perms),
        .o_mode                  (dec_mode),
        .o_code_ok               (dec_ok)
    );

    cpc_perm_restrict #(
        .HYBRID      (HYBRID)
    ) u_restrict (
        .i_cur_perms (dec_perms),
        .i_keep_mask (i_keep_mask),
        .i_mode      (dec_mode),
        .o_field     (restr_field)
    );

    // mode write reuses the encoder with nothing removed, so only the mode moves
    cpc_perm_restrict #(
        .HYBRID      (HYBRID)
    ) u_mode_write (
        .i_cur_perms (dec_perms),
        .i_keep_mask ('1),
        .i_mode      (i_new_mode),
        .o_field     (modew_field)
    );

    // ------------------------------------------------------------------------
    // state update
    // ------------------------------------------------------------------------
    cpc_pkg::cpc_state_t state_q;
    cpc_pkg::cpc_state_t state_d;
    logic                is_inf;

    always_comb begin
        state_d = state_q;
        is_inf  = (i_spc_sel == cpc_pkg::CPC_SPC_INFINITE);
        if (i_ce) begin
            state_d.read_perms  = dec_perms;
            state_d.read_mode   = dec_mode;
            state_d.code_ok     = dec_ok;
            // global flag stays reserved since the levels extension is not built
            state_d.fmt_ok      = dec_ok && !(|i_reserved_bits)
                                  && !i_unbounded_lifetime_flag;
            state_d.restr_field = restr_field;
            state_d.modew_field = modew_field;
            state_d.spc_tag     = is_inf;
            state_d.spc_sdp     = is_inf ? '1 : '0;
            state_d.spc_field   = !is_inf ? `CPC_CODE_NONE :
                                  HYBRID ? `CPC_FULL_CODE_HYBRID : `CPC_FULL_CODE;
            state_d.spc_ext_perm = is_inf;
            // any address is legal for the infinite value; the null value is all zero
            state_d.spc_addr    = is_inf ? i_spc_addr : `CPC_RST_ADDR;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rstn_sync) begin
        if (!rstn_sync) begin
            state_q             <= '0;
            state_q.restr_field <= `CPC_RST_FIELD;
            state_q.modew_field <= `CPC_RST_FIELD;
            state_q.spc_field   <= `CPC_RST_FIELD;
            state_q.spc_addr    <= `CPC_RST_ADDR;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign o_read_perms   = state_q.read_perms;
    assign o_read_mode    = state_q.read_mode;
    assign o_code_ok      = state_q.code_ok;
    assign o_fmt_ok       = state_q.fmt_ok;
    assign o_restr_field  = state_q.restr_field;
    assign o_modew_field  = state_q.modew_field;
    assign o_spc_tag      = state_q.spc_tag;
    assign o_spc_sdp      = state_q.spc_sdp;
    assign o_spc_field    = state_q.spc_field;
    assign o_spc_ext_perm = state_q.spc_ext_perm;
    assign o_spc_addr     = state_q.spc_addr;

    // unsealed, internal exponent, zero bounds for both special values
    assign o_spc_seal_type_bit        = 1'b0;
    assign o_spc_exponent_format_flag = 1'b0;
    assign o_spc_length_msb_bit       = 1'b0;
    assign o_spc_top                  = '0;
    assign o_spc_base                 = '0;

    assign o_max_exponent                  = EXP_WIDTH'(`CPC_MAX_EXP);
    assign o_length_msb_bit_present        = `CPC_LEN_MSB_PRESENT;
    assign o_mode_bit_in_permission_field  = `CPC_MODE_IN_FIELD;
    // margin below base and above top is size shifted right by this
    assign o_repr_margin_shift             = 4'(`CPC_REPR_SHIFT);

endmodule

`default_nettype wire

/* tb/cpc_dp_model.sv */
// datapath model that feeds the codec a capability field, fresh or written back
`default_nettype none

module cpc_dp_model (
    // selection
    input  wire logic       i_use_wb,
    // sources
    input  wire logic [4:0] i_field,
    input  wire logic [4:0] i_result,
    // to the codec
    output logic [4:0]      o_field
);
    timeunit 1ns;
    timeprecision 100ps;
    // a written-back result goes straight round, as a register file read would
    assign o_field = i_use_wb ? i_result : i_field;
endmodule

`default_nettype wire

/* tb/cpc_perm_codec_chk.sv */
// assertions on the ports of the capability permission codec
`default_nettype none

module cpc_perm_codec_chk #(
    parameter bit          HYBRID     = 1'b0,
    parameter int unsigned RESV_WIDTH = 1,
    parameter int unsigned EXP_WIDTH  = 5
) (
    // clock, reset, enable
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rstn,
    input  wire logic                  i_ce,
    // inputs
    input  wire logic [4:0]            i_arch_permission_field,
    input  wire logic                  i_unbounded_lifetime_flag,
    input  wire logic [RESV_WIDTH-1:0] i_reserved_bits,
    input  var  cpc_pkg::cpc_spc_t     i_spc_sel,
    input  wire logic [31:0]           i_spc_addr,
    // outputs
    input  var  cpc_pkg::cpc_perm_t    o_read_perms,
    input  wire logic                  o_read_mode,
    input  wire logic                  o_code_ok,
    input  wire logic                  o_fmt_ok,
    input  wire logic [4:0]            o_restr_field,
    input  wire logic [4:0]            o_modew_field,
    input  wire logic                  o_spc_tag,
    input  wire logic [1:0]            o_spc_sdp,
    input  wire logic [4:0]            o_spc_field,
    input  wire logic                  o_spc_ext_perm,
    input  wire logic [31:0]           o_spc_addr,
    input  wire logic [EXP_WIDTH-1:0]  o_max_exponent,
    input  wire logic                  o_length_msb_bit_present,
    input  wire logic                  o_mode_bit_in_permission_field,
    input  wire logic [3:0]            o_repr_margin_shift
);
    timeunit 1ns;
    timeprecision 100ps;
    // one bit for each code of the field that is not reserved
    localparam logic [31:0] LEGAL = 32'h8808_5533 | (HYBRID ? 32'h0000_AA00 : 32'h0000_0000);
    logic [2:0] live_q;
    wire  logic take = live_q[2] && i_ce;

    // the design holds its outputs clear for two edges after release; wait that out
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            live_q <= 3'h0;
        end else begin
            live_q <= {live_q[1:0], 1'b1};
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    null_value_a: assert property (
        take && i_spc_sel == cpc_pkg::CPC_SPC_NULL |=> {o_spc_tag, o_spc_sdp, o_spc_field,
        o_spc_ext_perm, o_spc_addr} == '0) else $error("null value has a set field");
    inf_value_a: assert property (
        take && i_spc_sel == cpc_pkg::CPC_SPC_INFINITE |=> o_spc_tag && o_spc_sdp == 2'h3
        && o_spc_ext_perm && o_spc_field == (HYBRID ? 5'h09 : 5'h08)
        && o_spc_addr == $past(i_spc_addr)) else $error("infinite value fields wrong");
    fmt_const_a: assert property (
        o_max_exponent == 5'h18 && o_length_msb_bit_present && o_mode_bit_in_permission_field
        && o_repr_margin_shift == 4'h2) else $error("format constant wrong");
    fmt_ok_a: assert property (
        take |=> o_fmt_ok == (o_code_ok && $past(i_reserved_bits) == '0
        && !$past(i_unbounded_lifetime_flag))) else $error("format check wrong");
    legal_code_a: assert property (
        take |=> o_code_ok == LEGAL[$past(i_arch_permission_field)])
        else $error("code validity wrong");
    resv_none_a: assert property (
        !o_code_ok |-> o_read_perms == '0 && !o_read_mode) else $error("reserved code grants");
    mode_gate_a: assert property (
        o_read_mode |-> HYBRID && o_read_perms.x) else $error("mode bit without execute");
    restr_legal_a: assert property (
        LEGAL[o_restr_field] && LEGAL[o_modew_field]) else $error("reserved code produced");
    mode_write_a: assert property (
        take ##1 o_code_ok |-> HYBRID || o_modew_field == $past(i_arch_permission_field))
        else $error("mode write changed permissions");
    ce_hold_a: assert property (
        live_q[2] && !i_ce |=> $stable(o_restr_field) && $stable(o_read_perms)
        && $stable(o_spc_tag)) else $error("outputs moved while disabled");

    cover property (take && i_spc_sel == cpc_pkg::CPC_SPC_INFINITE);
    cover property (take ##1 o_restr_field != o_modew_field);
    cover property (live_q[2] && !i_ce);
endmodule

bind cpc_perm_codec cpc_perm_codec_chk #(
    .HYBRID(HYBRID), .RESV_WIDTH(RESV_WIDTH), .EXP_WIDTH(EXP_WIDTH)
) i_cpc_perm_codec_chk (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_arch_permission_field(i_arch_permission_field),
    .i_unbounded_lifetime_flag(i_unbounded_lifetime_flag),
    .i_reserved_bits(i_reserved_bits), .i_spc_sel(i_spc_sel), .i_spc_addr(i_spc_addr),
    .o_read_perms(o_read_perms), .o_read_mode(o_read_mode), .o_code_ok(o_code_ok),
    .o_fmt_ok(o_fmt_ok), .o_restr_field(o_restr_field), .o_modew_field(o_modew_field),
    .o_spc_tag(o_spc_tag), .o_spc_sdp(o_spc_sdp), .o_spc_field(o_spc_field),
    .o_spc_ext_perm(o_spc_ext_perm), .o_spc_addr(o_spc_addr),
    .o_max_exponent(o_max_exponent), .o_length_msb_bit_present(o_length_msb_bit_present),
    .o_mode_bit_in_permission_field(o_mode_bit_in_permission_field),
    .o_repr_margin_shift(o_repr_margin_shift)
);

`default_nettype wire

/* tb/tb_cpc_perm_codec.sv */
// self-checking testbench of the capability permission codec
`default_nettype none

module tb_cpc_perm_codec;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] LEGAL = 32'h8808_5533;
    typedef struct packed {
        logic [4:0] fld;
        logic [5:0] mask;
        logic [5:0] perms;
        logic [4:0] restr;
    } cpc_row_t;
    // field, kept permissions (r w c lm x asr), decoded permissions, restricted field
    cpc_row_t rows [26] = '{
        '{5'h00, 6'h3F, 6'h00, 5'h00}, '{5'h01, 6'h3F, 6'h20, 5'h01},
        '{5'h04, 6'h3F, 6'h10, 5'h04}, '{5'h05, 6'h3F, 6'h30, 5'h05},
        '{5'h08, 6'h3F, 6'h3F, 5'h08}, '{5'h0A, 6'h3F, 6'h2E, 5'h0A},
        '{5'h0C, 6'h3F, 6'h3E, 5'h0C}, '{5'h0E, 6'h3F, 6'h32, 5'h0E},
        '{5'h13, 6'h3F, 6'h28, 5'h13}, '{5'h1B, 6'h3F, 6'h2C, 5'h1B},
        '{5'h1F, 6'h3F, 6'h3C, 5'h1F}, '{5'h08, 6'h1F, 6'h3F, 5'h04},
        '{5'h08, 6'h3E, 6'h3F, 5'h0C}, '{5'h08, 6'h3B, 6'h3F, 5'h13},
        '{5'h08, 6'h37, 6'h3F, 5'h0E}, '{5'h08, 6'h2F, 6'h3F, 5'h0A},
        '{5'h1F, 6'h1F, 6'h3C, 5'h04}, '{5'h0E, 6'h2F, 6'h32, 5'h01},
        '{5'h1F, 6'h2F, 6'h3C, 5'h1B}, '{5'h1F, 6'h3B, 6'h3C, 5'h13},
        '{5'h0A, 6'h37, 6'h2E, 5'h01}, '{5'h0C, 6'h3D, 6'h3E, 5'h1F},
        '{5'h02, 6'h3F, 6'h00, 5'h00}, '{5'h09, 6'h3F, 6'h00, 5'h00},
        '{5'h16, 6'h3F, 6'h00, 5'h00}, '{5'h1E, 6'h3F, 6'h00, 5'h00}};
    logic               clk_sys = 1'b0;
    logic               rstn;
    logic               ce;
    logic               glob;
    logic               resv;
    logic               new_mode;
    logic               use_wb;
    logic [4:0]         fld_src;
    logic [4:0]         fld;
    logic [31:0]        addr;
    cpc_pkg::cpc_perm_t mask;
    cpc_pkg::cpc_spc_t  sel;
    cpc_pkg::cpc_perm_t perms;
    logic               rmode, code_ok, fmt_ok, s_tag, s_ct, s_ef, s_l8, s_ext, l8p, mbf;
    logic [4:0]         restr, modew, s_fld, max_e;
    logic [1:0]         s_sdp;
    logic [9:0]         s_top, s_base;
    logic [31:0]        s_addr;
    logic [3:0]         rshift;
    int unsigned        n_fail = 0;
    int unsigned        total_checks = 0;
    int unsigned        cycles = 0;

    always #2.5 clk_sys = ~clk_sys;

    cpc_dp_model i_cpc_dp_model (.i_use_wb(use_wb), .i_field(fld_src), .i_result(restr),
        .o_field(fld));

    cpc_perm_codec i_cpc_perm_codec (
        .i_clk_sys(clk_sys), .i_rstn(rstn), .i_ce(ce), .i_arch_permission_field(fld),
        .i_tag(1'b1), .i_unbounded_lifetime_flag(glob), .i_reserved_bits(resv),
        .i_keep_mask(mask), .i_new_mode(new_mode), .i_spc_sel(sel), .i_spc_addr(addr),
        .o_read_perms(perms), .o_read_mode(rmode), .o_code_ok(code_ok), .o_fmt_ok(fmt_ok),
        .o_restr_field(restr), .o_modew_field(modew), .o_spc_tag(s_tag), .o_spc_sdp(s_sdp),
        .o_spc_field(s_fld), .o_spc_seal_type_bit(s_ct), .o_spc_exponent_format_flag(s_ef),
        .o_spc_length_msb_bit(s_l8), .o_spc_top(s_top), .o_spc_base(s_base),
        .o_spc_ext_perm(s_ext), .o_spc_addr(s_addr), .o_max_exponent(max_e),
        .o_length_msb_bit_present(l8p), .o_mode_bit_in_permission_field(mbf),
        .o_repr_margin_shift(rshift));

    task automatic end_sim();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // inputs settle 1 ns after an edge; results are looked at 1 ns after the next
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        {rstn, glob, resv, new_mode, use_wb, fld_src, addr} = '0;
        ce = 1'b1;
        mask = 6'h3F;
        sel = cpc_pkg::CPC_SPC_NULL;
        repeat (2) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        repeat (3) tick();
        foreach (rows[k]) begin
            fld_src = rows[k].fld;
            mask = rows[k].mask;
            new_mode = k[0];
            tick();
            chk(perms, rows[k].perms);
            chk(restr, rows[k].restr);
            chk(modew, LEGAL[rows[k].fld] ? rows[k].fld : 5'h00);
            chk(rmode, 1'b0);
        end
        for (int f = 0; f < 32; f++) begin
            fld_src = f[4:0];
            resv = (f == 5);
            glob = (f == 8);
            tick();
            chk(code_ok, LEGAL[f]);
            chk(fmt_ok, LEGAL[f] && f != 5 && f != 8);
        end
        // infinite then null back to back
        sel = cpc_pkg::CPC_SPC_INFINITE;
        addr = 32'hA5C3_0F12;
        tick();
        chk({s_tag, s_sdp, s_fld, s_ext}, {1'b1, 2'h3, 5'h08, 1'b1});
        chk(s_addr, 32'hA5C3_0F12);
        chk({s_ct, s_ef, s_l8, s_top, s_base}, 32'h0000_0000);
        chk({max_e, l8p, mbf, rshift}, {5'h18, 1'b1, 1'b1, 4'h2});
        sel = cpc_pkg::CPC_SPC_NULL;
        tick();
        chk({s_tag, s_sdp, s_fld, s_ext, s_ct, s_ef, s_l8, s_top, s_base}, 32'h0);
        chk({s_addr}, 32'h0000_0000);
        // disabled: a new request must leave everything where it was
        ce = 1'b0;
        sel = cpc_pkg::CPC_SPC_INFINITE;
        fld_src = 5'h08;
        mask = 6'h3B;
        tick();
        // the last enabled request restricted field 0x1F with a full mask
        chk({s_tag, restr}, {1'b0, 5'h1F});
        ce = 1'b1;
        tick();
        chk(restr, 5'h13);
        // the restricted field goes back in and must come out unchanged
        use_wb = 1'b1;
        mask = 6'h3F;
        repeat (2) begin
            tick();
            chk({perms, restr}, {6'h28, 5'h13});
        end
        use_wb = 1'b0;
        // reset in mid-run clears at once and the next request is taken again
        rstn = 1'b0;
        #1;
        chk({s_tag, perms, restr}, 32'h0);
        tick();
        rstn = 1'b1;
        fld_src = 5'h0C;
        mask = 6'h3D;
        repeat (4) tick();
        chk(restr, 5'h1F);
        end_sim();
    end
endmodule

`default_nettype wire
